// [dispatch_props.sv]
// Checker for the event dispatcher's pulses, program reset and idle behaviour.
`timescale 1ns/1ps
module dispatch_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Register port.
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  // Control outputs.
  input wire logic        program_run,
  input wire logic        program_reset,
  input wire logic        force_stop,
  input wire logic        program_end,
  input wire logic        direction_reverse,
  input wire logic        setting_locked,
  input wire logic        comm_write_ok,
  input wire logic        water_cooling_adjust_en,
  input wire logic        alarm_latch_clear,
  input wire logic        pid_update_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [15:0] sel_q;
  logic [15:0] sel_d;
  logic        dir_q;
  logic        dir_d;
  logic        sel_none;

  // Shadow copies follow only writes the block accepts, so a lockout never skews them.
  always_comb
  begin
    sel_d = sel_q;
    dir_d = dir_q;
    if (reg_wr && !setting_locked && reg_addr == 4'h0)
      sel_d = reg_wdata;
    if (reg_wr && !setting_locked && reg_addr == 4'h6)
      dir_d = reg_wdata[0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_q <= 16'h0000;
      dir_q <= 1'b0;
    end
    else
    begin
      sel_q <= sel_d;
      dir_q <= dir_d;
    end
  end

  assign sel_none = (sel_q == 16'h0000);

  property p_reset_pair;
    program_reset |-> force_stop;
  endproperty
  a_reset_pair: assert property (p_reset_pair) else $error("program reset without forced stop");

  property p_stop_pair;
    force_stop |-> program_reset;
  endproperty
  a_stop_pair: assert property (p_stop_pair) else $error("forced stop without program reset");

  property p_reset_pulse;
    program_reset |=> !program_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("program reset longer than one cycle");

  property p_run_off;
    program_reset |-> !program_run;
  endproperty
  a_run_off: assert property (p_run_off) else $error("program still running after reset");

  property p_end_clear;
    program_reset |-> !program_end;
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("program end not cleared by reset");

  property p_alarm_pulse;
    alarm_latch_clear |=> !alarm_latch_clear;
  endproperty
  a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm clear longer than one cycle");

  property p_pid_pulse;
    pid_update_start |=> !pid_update_start;
  endproperty
  a_pid_pulse: assert property (p_pid_pulse) else $error("PID update longer than one cycle");

  property p_none_quiet;
    (sel_none && $past(sel_q) == 16'h0000 && $past(sel_q, 3) == 16'h0000)
      |-> !setting_locked && !comm_write_ok && !water_cooling_adjust_en;
  endproperty
  a_none_quiet: assert property (p_none_quiet) else $error("unassigned input had an effect");

  property p_dir_plain;
    (sel_none && $past(sel_q, 3) == 16'h0000 && $stable(dir_q) && $past(dir_q, 3) == dir_q)
      |-> direction_reverse == dir_q;
  endproperty
  a_dir_plain: assert property (p_dir_plain) else $error("direction differs from setting");

  c_reset: cover property (program_reset);
  c_alarm: cover property (alarm_latch_clear);
  c_pid: cover property (pid_update_start);
  c_lock: cover property ($rose(setting_locked));
endmodule

// [event_contacts.sv]
// Model of the field contacts that drive the event inputs.
`timescale 1ns/1ps
module event_contacts (
  // Clock.
  input wire logic       clk,
  // Requested contact levels and short disturbances.
  input wire logic [3:0] level,
  input wire logic [3:0] glitch,
  // Contact outputs.
  output logic [3:0]     event_in
);
  // Levels are held until asked to change; a glitch models a bounce shorter than the hold time.
  always_ff @(posedge clk)
  begin
    event_in <= level ^ glitch;
  end
endmodule

// [event_dispatch_consts.svh]
// Constants for the event input dispatcher and set point limiter.
`ifndef EVENT_DISPATCH_CONSTS_SVH
`define EVENT_DISPATCH_CONSTS_SVH

// Register offsets.
`define OFS_FUNC_SELECT   4'h0
`define OFS_SP_UPPER      4'h1
`define OFS_SP_LOWER      4'h2
`define OFS_SP_VALUE      4'h3
`define OFS_RANGE_UPPER   4'h4
`define OFS_RANGE_LOWER   4'h5
`define OFS_CONTROL       4'h6
`define OFS_STATUS        4'h7
`define OFS_PULSES        4'h8

// Function select field: four bits per input, input n at bits 4n+3..4n.
`define FSEL_WIDTH        4

// Control register bit positions.
`define CTL_DIR_REVERSE   0
`define CTL_RANGE_CHANGE  1
`define CTL_PROG_END_SET  2

// Reset values.
`define RST_SP_UPPER      16'h0514
`define RST_SP_LOWER      16'hFF38
`define RST_SP_VALUE      16'h0000
`define RST_FUNC_SELECT   16'h0000

// Event input debounce: 50 ms at 20 MHz.
`define DEBOUNCE_MS       50
`define CLK_KHZ           20000
`define DEBOUNCE_CYCLES   (`DEBOUNCE_MS * `CLK_KHZ)

`endif

// [event_dispatch_pkg.sv]
// Types shared by the event input dispatcher files.
package event_dispatch_pkg;

  typedef enum logic [3:0] {
    FN_NONE                       = 4'h0,
    FN_PROGRAM_LAUNCH_ASSIGN      = 4'h1,
    FN_DIRECTION_INVERT_ASSIGN    = 4'h2,
    FN_FULL_AUTOTUNE_ASSIGN       = 4'h3,
    FN_REDUCED_AUTOTUNE_ASSIGN    = 4'h4,
    FN_SETTING_LOCKOUT_ASSIGN     = 4'h5,
    FN_COMM_WRITE_ENABLE_ASSIGN   = 4'h6,
    FN_ALARM_HOLD_RELEASE_ASSIGN  = 4'h7,
    FN_ADAPTIVE_GAIN_REFRESH_ASSIGN = 4'h8,
    FN_SMOOTHING_TUNE_ASSIGN      = 4'h9,
    FN_WATER_COOLING_TUNE_ASSIGN  = 4'hA
  } func_e;

  typedef enum logic [1:0] {
    LIM_IDLE,
    LIM_CLAMP_UPPER,
    LIM_CLAMP_LOWER
  } lim_state_e;

endpackage

// [event_input_dispatch_sp_limiter.sv]
// Event input function dispatcher with set point limiter.
//
// How it works
// - Program-launch input going active starts the simple program.
// - Program-launch input going inactive resets the program and forces stop.
// - That program reset also clears the program-end output.
// - Direction-invert input active flips the configured direct/reverse direction.
// - Full autotune runs while its input is active, cancels when inactive.
// - Reduced autotune starts on input active, cancels on inactive.
// - Setting-lockout input active refuses parameter changes.
// - Comm-write-enable input active permits communications writes, inactive rejects.
// - Alarm-hold-release input turning active clears all latched alarms.
// - Adaptive-gain-refresh input turning active starts a PID update.
// - Smoothing-tune input active performs filter adjustment, inactive cancels it.
// - Water-cooling-tune adjustment enabled while its input is active.
// - Each of four inputs has its own function selection.
// - Newly entered set points are clamped within the limiter bounds.
// - A bound change that strands the set point replaces it with that bound.
// - Input range change forces limiter bounds back to range limits.
// - Input level changes count only after holding 50 ms.
// - Edge functions act on changes; power-up level counts as an edge.
`timescale 1ns/1ps
`include "event_dispatch_consts.svh"

module event_input_dispatch_sp_limiter #(
  parameter int NUM_INPUTS  = 4,
  parameter int SP_WIDTH    = 16,
  parameter int HOLD_CYCLES = `DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // External event contacts.
  input  wire logic [NUM_INPUTS-1:0] event_in,
  // Register port.
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [15:0]              reg_rdata,
  // Control outputs.
  output logic                     program_run,
  output logic                     program_reset,
  output logic                     force_stop,
  output logic                     program_end,
  output logic                     direction_reverse,
  output logic                     full_autotune_run,
  output logic                     reduced_autotune_run,
  output logic                     setting_locked,
  output logic                     comm_write_ok,
  output logic                     alarm_latch_clear,
  output logic                     pid_update_start,
  output logic                     filter_adjust_run,
  output logic                     water_cooling_adjust_en,
  output logic [SP_WIDTH-1:0]      setpoint
);

  logic [NUM_INPUTS-1:0] lvl;
  logic [NUM_INPUTS-1:0] lvl_prev_q;
  logic                  first_q;
  logic [NUM_INPUTS-1:0] rise;
  logic [NUM_INPUTS-1:0] fall;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_in
      input_debounce #(
        .HOLD_CYCLES (HOLD_CYCLES)
      ) u_deb (
        .clk       (clk),
        .rst       (rst),
        .raw_in    (event_in[gi]),
        .level_out (lvl[gi])
      );
      // The first cycle after reset counts the present level as an edge.
      assign rise[gi] = lvl[gi] & (~lvl_prev_q[gi] | first_q);
      assign fall[gi] = ~lvl[gi] & (lvl_prev_q[gi] | first_q);
    end
  endgenerate

  // Configuration state.
  logic [15:0]         fsel_q;
  logic [15:0]         fsel_d;
  logic [SP_WIDTH-1:0] sp_hi_q;
  logic [SP_WIDTH-1:0] sp_hi_d;
  logic [SP_WIDTH-1:0] sp_lo_q;
  logic [SP_WIDTH-1:0] sp_lo_d;
  logic [SP_WIDTH-1:0] sp_q;
  logic [SP_WIDTH-1:0] sp_d;
  logic [SP_WIDTH-1:0] rng_hi_q;
  logic [SP_WIDTH-1:0] rng_hi_d;
  logic [SP_WIDTH-1:0] rng_lo_q;
  logic [SP_WIDTH-1:0] rng_lo_d;
  logic                dir_cfg_q;
  logic                dir_cfg_d;
  logic [15:0]         rdata_q;
  logic [15:0]         rdata_d;
  logic [SP_WIDTH-1:0] wsp;

  // Function outputs.
  logic prun_q, prun_d, program_launch_assign_q, program_launch_assign_d, fstop_q, fstop_d, pend_q, pend_d;
  logic dir_q, dir_d, fat_q, fat_d, rat_q, rat_d, lock_q, lock_d;
  logic comm_q, comm_d, aclr_q, aclr_d, pidu_q, pidu_d, filt_q, filt_d, wcool_q, wcool_d;

  event_dispatch_pkg::func_e fn;

  always_comb
  begin
    prun_d  = prun_q;
    program_launch_assign_d  = 1'b0;
    fstop_d = 1'b0;
    pend_d  = pend_q;
    dir_d   = dir_cfg_q;
    fat_d   = fat_q;
    rat_d   = rat_q;
    lock_d  = 1'b0;
    comm_d  = 1'b0;
    aclr_d  = 1'b0;
    pidu_d  = 1'b0;
    filt_d  = filt_q;
    wcool_d = 1'b0;
    fn      = event_dispatch_pkg::FN_NONE;
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      fn = event_dispatch_pkg::func_e'(fsel_q[i*`FSEL_WIDTH +: `FSEL_WIDTH]);
      case (fn)
        event_dispatch_pkg::FN_PROGRAM_LAUNCH_ASSIGN:
        begin
          if (rise[i])
          begin
            prun_d = 1'b1;
          end
          if (fall[i])
          begin
            prun_d  = 1'b0;
            program_launch_assign_d  = 1'b1;
            fstop_d = 1'b1;
            pend_d  = 1'b0;
          end
        end
        event_dispatch_pkg::FN_DIRECTION_INVERT_ASSIGN:
        begin
          if (lvl[i])
          begin
            dir_d = ~dir_cfg_q;
          end
        end
        event_dispatch_pkg::FN_FULL_AUTOTUNE_ASSIGN:
        begin
          if (rise[i])
          begin
            fat_d = 1'b1;
          end
          if (fall[i])
          begin
            fat_d = 1'b0;
          end
        end
        event_dispatch_pkg::FN_REDUCED_AUTOTUNE_ASSIGN:
        begin
          if (rise[i])
          begin
            rat_d = 1'b1;
          end
          if (fall[i])
          begin
            rat_d = 1'b0;
          end
        end
        event_dispatch_pkg::FN_SETTING_LOCKOUT_ASSIGN:
        begin
          lock_d = lock_d | lvl[i];
        end
        event_dispatch_pkg::FN_COMM_WRITE_ENABLE_ASSIGN:
        begin
          comm_d = comm_d | lvl[i];
        end
        event_dispatch_pkg::FN_ALARM_HOLD_RELEASE_ASSIGN:
        begin
          aclr_d = aclr_d | rise[i];
        end
        event_dispatch_pkg::FN_ADAPTIVE_GAIN_REFRESH_ASSIGN:
        begin
          pidu_d = pidu_d | rise[i];
        end
        event_dispatch_pkg::FN_SMOOTHING_TUNE_ASSIGN:
        begin
          if (rise[i])
          begin
            filt_d = 1'b1;
          end
          if (fall[i])
          begin
            filt_d = 1'b0;
          end
        end
        event_dispatch_pkg::FN_WATER_COOLING_TUNE_ASSIGN:
        begin
          wcool_d = wcool_d | lvl[i];
        end
        default:
        begin
          // No function: the input is ignored.
          prun_d = prun_d;
        end
      endcase
    end
    // Program end is set by a control register write with CTL_PROG_END_SET; a reset in the same cycle wins over it.
    if (reg_wr && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_PROG_END_SET] && !program_launch_assign_d)
    begin
      pend_d = 1'b1;
    end
  end

  // Clamp a written value into the limiter window.
  function automatic logic [SP_WIDTH-1:0] clamp(input logic [SP_WIDTH-1:0] v,
                                                input logic [SP_WIDTH-1:0] lo,
                                                input logic [SP_WIDTH-1:0] hi);
    logic [SP_WIDTH-1:0] r;
    r = v;
    if ($signed(v) > $signed(hi))
    begin
      r = hi;
    end
    else if ($signed(v) < $signed(lo))
    begin
      r = lo;
    end
    return r;
  endfunction

  always_comb
  begin
    fsel_d    = fsel_q;
    sp_hi_d   = sp_hi_q;
    sp_lo_d   = sp_lo_q;
    sp_d      = sp_q;
    rng_hi_d  = rng_hi_q;
    rng_lo_d  = rng_lo_q;
    dir_cfg_d = dir_cfg_q;
    rdata_d   = 16'h0000;
    wsp       = reg_wdata[SP_WIDTH-1:0];
    // Lockout refuses every parameter write; reads and the program-end request at CTL_PROG_END_SET still pass.
    if (reg_wr && !lock_q)
    begin
      case (reg_addr)
        `OFS_FUNC_SELECT: fsel_d = reg_wdata;
        `OFS_SP_UPPER:    sp_hi_d = clamp(wsp, sp_lo_q, rng_hi_q);
        `OFS_SP_LOWER:    sp_lo_d = clamp(wsp, rng_lo_q, sp_hi_q);
        `OFS_SP_VALUE:    sp_d = clamp(wsp, sp_lo_q, sp_hi_q);
        `OFS_RANGE_UPPER: rng_hi_d = wsp;
        `OFS_RANGE_LOWER: rng_lo_d = wsp;
        `OFS_CONTROL:
        begin
          dir_cfg_d = reg_wdata[`CTL_DIR_REVERSE];
          if (reg_wdata[`CTL_RANGE_CHANGE])
          begin
            sp_hi_d = rng_hi_q;
            sp_lo_d = rng_lo_q;
          end
        end
        default:
        begin
          rdata_d = 16'h0000;
        end
      endcase
    end
    // Pull the set point back inside whenever the window moved past it.
    sp_d = clamp(sp_d, sp_lo_d, sp_hi_d);
    if (reg_rd)
    begin
      case (reg_addr)
        `OFS_FUNC_SELECT: rdata_d = fsel_q;
        `OFS_SP_UPPER:    rdata_d = 16'(sp_hi_q);
        `OFS_SP_LOWER:    rdata_d = 16'(sp_lo_q);
        `OFS_SP_VALUE:    rdata_d = 16'(sp_q);
        `OFS_RANGE_UPPER: rdata_d = 16'(rng_hi_q);
        `OFS_RANGE_LOWER: rdata_d = 16'(rng_lo_q);
        `OFS_CONTROL:     rdata_d = {15'h0000, dir_cfg_q};
        `OFS_STATUS:      rdata_d = {3'h0, wcool_q, filt_q, comm_q, lock_q, rat_q, fat_q, dir_q, pend_q,
                                     prun_q, lvl_prev_q};
        default:          rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lvl_prev_q <= '0;
      first_q    <= 1'b1;
      fsel_q     <= `RST_FUNC_SELECT;
      sp_hi_q    <= SP_WIDTH'(`RST_SP_UPPER);
      sp_lo_q    <= SP_WIDTH'(`RST_SP_LOWER);
      sp_q       <= SP_WIDTH'(`RST_SP_VALUE);
      rng_hi_q   <= SP_WIDTH'(`RST_SP_UPPER);
      rng_lo_q   <= SP_WIDTH'(`RST_SP_LOWER);
      dir_cfg_q  <= 1'b0;
      rdata_q    <= 16'h0000;
      {prun_q, program_launch_assign_q, fstop_q, pend_q, dir_q, fat_q, rat_q} <= 7'h00;
      {lock_q, comm_q, aclr_q, pidu_q, filt_q, wcool_q}      <= 6'h00;
    end
    else
    begin
      lvl_prev_q <= lvl;
      first_q    <= 1'b0;
      fsel_q     <= fsel_d;
      sp_hi_q    <= sp_hi_d;
      sp_lo_q    <= sp_lo_d;
      sp_q       <= sp_d;
      rng_hi_q   <= rng_hi_d;
      rng_lo_q   <= rng_lo_d;
      dir_cfg_q  <= dir_cfg_d;
      rdata_q    <= rdata_d;
      {prun_q, program_launch_assign_q, fstop_q, pend_q, dir_q, fat_q, rat_q} <= {prun_d, program_launch_assign_d, fstop_d, pend_d, dir_d, fat_d, rat_d};
      {lock_q, comm_q, aclr_q, pidu_q, filt_q, wcool_q}      <= {lock_d, comm_d, aclr_d, pidu_d, filt_d, wcool_d};
    end
  end

  assign reg_rdata               = rdata_q;
  assign program_run             = prun_q;
  assign program_reset           = program_launch_assign_q;
  assign force_stop              = fstop_q;
  assign program_end             = pend_q;
  assign direction_reverse       = dir_q;
  assign full_autotune_run       = fat_q;
  assign reduced_autotune_run    = rat_q;
  assign setting_locked          = lock_q;
  assign comm_write_ok           = comm_q;
  assign alarm_latch_clear       = aclr_q;
  assign pid_update_start        = pidu_q;
  assign filter_adjust_run       = filt_q;
  assign water_cooling_adjust_en = wcool_q;
  assign setpoint                = sp_q;

endmodule

// [input_debounce.sv]
// Debounce filter for one event input: accepts a level only after it holds steadily.
`timescale 1ns/1ps
`include "event_dispatch_consts.svh"

module input_debounce #(
  parameter int HOLD_CYCLES = `DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Raw contact and filtered level.
  input  wire logic raw_in,
  output logic      level_out
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          level_q;
  logic          level_d;

  // The counter only runs while the raw level differs from the accepted one, so short glitches restart it.
  always_comb
  begin
    cnt_d   = '0;
    level_d = level_q;
    if (raw_in != level_q)
    begin
      if (cnt_q == CW'(HOLD_CYCLES - 1))
      begin
        level_d = raw_in;
      end
      else
      begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

endmodule

// [test_event_input_dispatch_sp_limiter.sv]
// Testbench for the event input dispatcher and set point limiter.
`timescale 1ns/1ps
module test_event_input_dispatch_sp_limiter;
  localparam int HOLD = 4;
  logic        clk, rst, reg_wr, reg_rd;
  logic [3:0]  reg_addr, level, glitch, event_in;
  logic [15:0] reg_wdata, reg_rdata, setpoint, rv;
  logic        program_run, program_reset, force_stop, program_end, direction_reverse;
  logic        full_autotune_run, reduced_autotune_run, setting_locked, comm_write_ok;
  logic        alarm_latch_clear, pid_update_start, filter_adjust_run, water_cooling_adjust_en;
  int          err_total, comparisons, n_alarm, n_pid, n_program_launch_assign, n_stop, n_lock;

  event_contacts u_contacts (.clk(clk), .level(level), .glitch(glitch), .event_in(event_in));

  event_input_dispatch_sp_limiter #(.HOLD_CYCLES(HOLD)) dut (
    .clk(clk), .rst(rst), .event_in(event_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .program_run(program_run),
    .program_reset(program_reset), .force_stop(force_stop), .program_end(program_end),
    .direction_reverse(direction_reverse), .full_autotune_run(full_autotune_run),
    .reduced_autotune_run(reduced_autotune_run), .setting_locked(setting_locked),
    .comm_write_ok(comm_write_ok), .alarm_latch_clear(alarm_latch_clear),
    .pid_update_start(pid_update_start), .filter_adjust_run(filter_adjust_run),
    .water_cooling_adjust_en(water_cooling_adjust_en), .setpoint(setpoint));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (!rst)
    begin
      n_alarm += int'(alarm_latch_clear);
      n_pid += int'(pid_update_start);
      n_program_launch_assign += int'(program_reset);
      n_stop += int'(force_stop);
      n_lock += int'(setting_locked);
    end
  end

  task summarize;
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Hold time plus the filter and output registers, with margin.
  task ev(input logic [3:0] v);
    @(posedge clk);
    level <= v;
    repeat (HOLD + 6) @(posedge clk);
    #1;
  endtask

  initial
  begin
    #2000000;
    err_total++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    level = 4'h0;
    glitch = 4'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(4'h1, rv); chk16(rv, 16'h0514);
    rd(4'h2, rv); chk16(rv, 16'hFF38);
    rd(4'hF, rv); chk16(rv, 16'h0000);
    wr(4'h1, 16'h03E8);
    wr(4'h2, 16'hFF9C);
    wr(4'h3, 16'h07D0); rd(4'h3, rv); chk16(rv, 16'h03E8);
    wr(4'h3, 16'hFED4); rd(4'h3, rv); chk16(rv, 16'hFF9C);
    wr(4'h3, 16'h01F4); wr(4'h1, 16'h0190); rd(4'h3, rv); chk16(rv, 16'h0190);
    wr(4'h1, 16'h03E8); wr(4'h3, 16'hFFCE); wr(4'h2, 16'h0000);
    rd(4'h3, rv); chk16(setpoint, 16'h0000);
    wr(4'h4, 16'h0320); wr(4'h5, 16'h0000); wr(4'h6, 16'h0002);
    rd(4'h1, rv); chk16(rv, 16'h0320);
    rd(4'h2, rv); chk16(rv, 16'h0000);
    // Level functions: lockout, write enable, water cooling, then inversion on input 3.
    wr(4'h0, 16'h2A65); wr(4'h6, 16'h0001);
    ev(4'h0); chk1(direction_reverse, 1'b1);
    ev(4'h8); chk1(direction_reverse, 1'b0);
    chk1(setting_locked, 1'b0);
    ev(4'h7); chk1(setting_locked, 1'b1);
    chk1(comm_write_ok, 1'b1);
    chk1(water_cooling_adjust_en, 1'b1);
    chk1(direction_reverse, 1'b1);
    wr(4'h3, 16'h0064); rd(4'h3, rv); chk16(rv, 16'h0000);
    ev(4'h0); chk1(setting_locked, 1'b0);
    chk1(comm_write_ok, 1'b0);
    chk1(water_cooling_adjust_en, 1'b0);
    // A bounce shorter than the hold time must never reach the lockout output.
    n_lock = 0;
    @(posedge clk);
    glitch <= 4'h1;
    repeat (HOLD - 2) @(posedge clk);
    glitch <= 4'h0;
    ev(4'h0); chk1(setting_locked, 1'b0);
    chk16(16'(n_lock), 16'h0000);
    // Edge functions: full tuning, alarm clear, PID update, filter adjustment.
    wr(4'h0, 16'h9873);
    ev(4'h0);
    n_alarm = 0;
    n_pid = 0;
    ev(4'hF); chk1(full_autotune_run, 1'b1);
    chk1(filter_adjust_run, 1'b1);
    ev(4'h0); chk1(full_autotune_run, 1'b0);
    chk1(filter_adjust_run, 1'b0);
    chk16(16'(n_alarm), 16'h0001);
    chk16(16'(n_pid), 16'h0001);
    // Reduced tuning on input 0, program launch on input 1.
    wr(4'h0, 16'h0014);
    ev(4'h0);
    n_program_launch_assign = 0;
    n_stop = 0;
    ev(4'h3); chk1(reduced_autotune_run, 1'b1);
    chk1(program_run, 1'b1);
    wr(4'h6, 16'h0004); rd(4'h7, rv); chk1(program_end, 1'b1);
    chk16(rv, 16'h0133);
    ev(4'h0); chk1(reduced_autotune_run, 1'b0);
    chk1(program_run, 1'b0);
    chk1(program_end, 1'b0);
    chk16(16'(n_program_launch_assign), 16'h0001);
    chk16(16'(n_stop), 16'h0001);
    // All inputs unassigned.
    wr(4'h0, 16'h0000); wr(4'h6, 16'h0000);
    ev(4'hF); chk1(setting_locked, 1'b0);
    chk1(full_autotune_run, 1'b0);
    chk1(program_run, 1'b0);
    chk1(direction_reverse, 1'b0);
    // Second reset with input 0 held active: the level present at start-up must act as an edge.
    @(posedge clk);
    rst <= 1'b1;
    level <= 4'h1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    n_alarm = 0;
    wr(4'h0, 16'h0007);
    ev(4'h1); chk16(16'(n_alarm), 16'h0001);
    chk16(setpoint, 16'h0000);
    rd(4'h1, rv); chk16(rv, 16'h0514);
    summarize();
  end
endmodule

bind event_input_dispatch_sp_limiter dispatch_props u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .program_run(program_run), .program_reset(program_reset), .force_stop(force_stop),
  .program_end(program_end), .direction_reverse(direction_reverse), .setting_locked(setting_locked),
  .comm_write_ok(comm_write_ok), .water_cooling_adjust_en(water_cooling_adjust_en),
  .alarm_latch_clear(alarm_latch_clear), .pid_update_start(pid_update_start));
